// ===== ccs_host_model.sv
// Purpose: Host side model that finishes started work and takes responses.
// Assumes: Work started by the unit ends three cycles later.
// Notes:   Each response byte is held off one cycle, like a slow reader.
module ccs_host_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic exec_start,
	input  wire logic exec_overlap,
	input  wire logic resp_valid,
	output logic      exec_done,
	output logic      ovl_done,
	output logic      resp_ready
);
	logic [2:0] sr_ff;
	logic       ov_ff;
	// A short delay line stands in for the neighbour doing the work.
	always_ff @(posedge clk) begin
		sr_ff <= rst_n ? {sr_ff[1:0], exec_start} : 3'h0;
		if (exec_start) ov_ff <= exec_overlap;
	end
	assign exec_done = sr_ff[2] & ~ov_ff;
	assign ovl_done  = sr_ff[2] & ov_ff;
	// Stalling every byte once proves the unit holds its answer.
	always_ff @(posedge clk) resp_ready <= rst_n & resp_valid & ~resp_ready;
endmodule

// ===== ccs_mem_if.sv
// Purpose: Carries the storage port between the controller and the store.
// Assumes: Read data appear one clock after the read strobe.
// Notes:   One shared address serves both reads and writes.
interface ccs_mem_if #(parameter int AW = 3, parameter int W = 8);
	logic          wr_en;
	logic          rd_en;
	logic [AW-1:0] addr;
	logic [W-1:0]  wdata;
	logic [W-1:0]  rdata;
	logic          rd_valid;
	modport ctrl (output wr_en, rd_en, addr, wdata, input rdata, rd_valid);
	modport mem  (input wr_en, rd_en, addr, wdata, output rdata, rd_valid);
endinterface

// ===== ccs_nvmem.sv
// Purpose: Nonvolatile store for the saved setting slots and the mask word.
// Assumes: Contents survive the reset; only the read strobe is reset.
// Notes:   Read data come from a register one cycle after the strobe.
module ccs_nvmem #(
	parameter int WORDS = 5,
	parameter int AW    = 3,
	parameter int W     = 8
) (
	input wire logic   clk,
	input wire logic   rst_n,
	ccs_mem_if.mem     mp
);
	logic [W-1:0] mem_ff [WORDS];

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	// The array has no reset on purpose, so saved slots outlive a reset.
	always_ff @(posedge clk) begin
		if (mp.wr_en) begin
			mem_ff[mp.addr] <= mp.wdata;
		end
		if (mp.rd_en) begin
			mp.rdata <= mem_ff[mp.addr];
		end
	end

	// Read strobe delayed to line up with the registered data.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mp.rd_valid <= 1'b0;
		end else begin
			mp.rd_valid <= mp.rd_en;
		end
	end
endmodule

// ===== ccs_pkg.sv
// Purpose: Shared constants and types of the common command and status unit.
// Assumes: One system clock; commands arrive already decoded.
// Notes:   The nonvolatile word packs both enable masks and the clear flag.
package ccs_pkg;

	// ------------------------------------------------------------------
	// Commands and internal states
	// ------------------------------------------------------------------
	typedef enum logic [4:0] {
		CMD_CLS   = 5'h00, CMD_ESE   = 5'h01, CMD_ESE_Q = 5'h02,
		CMD_ESR_Q = 5'h03, CMD_IDN_Q = 5'h04, CMD_OPC   = 5'h05,
		CMD_OPC_Q = 5'h06, CMD_OPT_Q = 5'h07, CMD_PSC   = 5'h08,
		CMD_PSC_Q = 5'h09, CMD_RCL   = 5'h0A, CMD_RST   = 5'h0B,
		CMD_SAV   = 5'h0C, CMD_SRE   = 5'h0D, CMD_SRE_Q = 5'h0E,
		CMD_STB_Q = 5'h0F, CMD_OTHER = 5'h10
	} ccs_cmd_t;

	typedef enum logic [2:0] {
		ST_PU_RD    = 3'b000, ST_PU_MASK = 3'b001, ST_RCL_WAIT = 3'b010,
		ST_IDLE     = 3'b011, ST_SEQ     = 3'b100, ST_OPCQ     = 3'b101,
		ST_NVWR     = 3'b110
	} ccs_fsm_t;

	typedef enum logic [1:0] {
		SLOPE_POS = 2'b00, SLOPE_NEG = 2'b01, SLOPE_EITHER = 2'b10
	} ccs_slope_t;

	// ------------------------------------------------------------------
	// Device settings that are saved, recalled and reset
	// ------------------------------------------------------------------
	typedef struct packed {
		logic        cal_on;
		logic        output_on;
		logic [15:0] volt_mv;
		logic [15:0] prot_delay_ms;
		logic [7:0]  acq_cnt_curr;
		logic [7:0]  acq_cnt_volt;
		logic [15:0] hyst_curr;
		logic [15:0] hyst_volt;
		logic [15:0] lev_curr;
		logic [15:0] lev_volt;
		ccs_slope_t  slope_curr;
		ccs_slope_t  slope_volt;
		logic        acq_src_bus;
		logic        tran_src_int;
		logic [15:0] sweep_points;
		logic [15:0] sample_int_ns;
	} ccs_state_t;

	localparam int STATE_W = $bits(ccs_state_t);

	// Protection delay of 0.08 s and sample interval of 15.6 us.
	localparam logic [15:0] PROT_DELAY_MS = 16'h0050;
	localparam logic [15:0] SWEEP_POINTS  = 16'h0800;
	localparam logic [15:0] SAMPLE_INT_NS = 16'h3CF0;

	localparam ccs_state_t RST_STATE = '{
		cal_on: 1'b0, output_on: 1'b0, volt_mv: 16'h0000,
		prot_delay_ms: PROT_DELAY_MS, acq_cnt_curr: 8'h01,
		acq_cnt_volt: 8'h01, hyst_curr: 16'h0000, hyst_volt: 16'h0000,
		lev_curr: 16'h0000, lev_volt: 16'h0000, slope_curr: SLOPE_POS,
		slope_volt: SLOPE_POS, acq_src_bus: 1'b0, tran_src_int: 1'b0,
		sweep_points: SWEEP_POINTS, sample_int_ns: SAMPLE_INT_NS};

	// ------------------------------------------------------------------
	// Event flags, status byte and storage layout
	// ------------------------------------------------------------------
	localparam int EV_PWR_UP  = 7;
	localparam int EV_CMD_ERR = 5;
	localparam int EV_EXE_ERR = 4;
	localparam int EV_DEV_ERR = 3;
	localparam int EV_QRY_ERR = 2;
	localparam int EV_OPS_DONE = 0;
	localparam logic [7:0] ESR_USED_MASK = 8'hBD;
	localparam logic [7:0] ESR_RESET     = 8'h80;
	localparam logic [7:0] STB_MSS_MASK  = 8'hBF;
	localparam int SB_MSS = 6;
	localparam int SB_ESB = 5;
	localparam int SB_MAV = 4;
	localparam logic [7:0] ASCII_ONE  = 8'h31;
	localparam logic [7:0] ASCII_ZERO = 8'h30;
	localparam logic [7:0] SLOT_COUNT = 8'h04;
	localparam int MEM_WORDS = 5;
	localparam int MEM_AW    = 3;
	localparam logic [2:0] NV_WORD_IDX = 3'h4;
	localparam int NV_ESE_LSB = 0;
	localparam int NV_SRE_LSB = 8;
	localparam int NV_PSC_BIT = 16;
endpackage

// ===== ccs_status_unit.sv
// Purpose: Common command handling, event flags and status summary.
// Assumes: Commands arrive decoded; neighbours run the settings and trigger.
// Notes:   Responses leave one byte at a time through a ready handshake.
import ccs_pkg::*;

// Behaviour
// - Clear-status zeroes event flags, status summaries and pulses neighbour clearing.
// - Clear-status after a terminator also empties the response and drops message bit.
// - Enabled event flags ORed together drive the event summary bit.
// - Eight-bit event enable mask is writable and readable back.
// - Flag layout fixed; bits 6 and 1 always read zero.
// - Reading the event flags returns them and then clears them.
// - Operations-done flag arms on request, sets once nothing is pending.
// - Pending means overlapped work outstanding or trigger actions busy.
// - Overlapped commands run alongside; others block until finished.
// - Blocking completion query stalls commands, then answers ASCII one.
// - Identity query returns four comma separated fields.
// - Options query answers ASCII zero when nothing is fitted.
// - With clear flag set, both masks clear at power-up.
// - With clear flag clear, both masks reload from storage at power-up.
// - Save copies present settings to slot 0 to 3.
// - Recall restores a slot and aborts the trigger system.
// - Recalled settings always have calibration switched off.
// - Power-up restores slot 0 when the power-up select asks for it.
// - Reset-to-defaults also aborts the trigger system.
// - Reset-to-defaults loads the fixed default settings table.
// - Status bits masked by service enable, ORed, drive bit 6.
// - Message bit clears at power-up, on clear-status after a terminator or when empty.
module ccs_status_unit #(
	parameter int          IDN_LEN = 21,
	// Identity string value is arbitrary.
	parameter logic [167:0] IDN_STR = "ACME,DCS01A,0,A.01.02",
	parameter int          PEND_W  = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             cmd_valid,
	input  wire ccs_pkg::ccs_cmd_t cmd_code,
	input  wire logic [7:0]       cmd_arg,
	input  wire logic             cmd_after_term,
	input  wire logic             cmd_overlap,
	output logic                  cmd_ready,
	output logic                  exec_start,
	output logic                  exec_overlap,
	input  wire logic             exec_done,
	input  wire logic             ovl_done,
	input  wire logic             trig_busy,
	input  wire logic             err_command,
	input  wire logic             err_execution,
	input  wire logic             err_device,
	input  wire logic             err_query,
	input  wire logic             oper_summary,
	input  wire logic             ques_summary,
	input  wire logic             power_up_state_select,
	input  wire ccs_pkg::ccs_state_t cur_state,
	output ccs_pkg::ccs_state_t   state_value,
	output logic                  state_load,
	output logic                  abort_trig,
	output logic                  clear_status,
	output logic                  flush_outq,
	output logic                  resp_valid,
	output logic [7:0]            resp_data,
	input  wire logic             resp_ready,
	output logic [7:0]            status_byte,
	output logic [7:0]            event_flags,
	output logic [7:0]            event_mask,
	output logic [7:0]            service_mask
);
	import ccs_pkg::*;

	localparam int IDXW = $clog2(IDN_LEN + 1);

	ccs_fsm_t            state_ff, nxt_state;
	logic [7:0]          esr_ff, nxt_esr, ese_ff, sre_ff, stb_ff;
	logic                psc_ff, opc_armed_ff, cmd_ready_ff;
	logic [PEND_W-1:0]   pend_ff;
	logic                resp_valid_ff, rsp_idn_ff;
	logic [7:0]          resp_data_ff, rsp_val_ff;
	logic [IDXW-1:0]     idx_ff, rsp_len_ff;
	logic                exec_start_ff, exec_overlap_ff;
	logic                state_load_ff, abort_ff, clear_ff, flush_ff;
	ccs_state_t          state_value_ff;
	logic                acc, is_q, q_drop, q_go, arg_ok, ops_idle, opc_set;
	logic                esr_clr, start, start_idn, event_summary_bit, mss;
	logic [7:0]          ev, start_val, stb_bits;

	ccs_mem_if #(.AW(MEM_AW), .W(STATE_W)) mif ();

	ccs_nvmem #(.WORDS(MEM_WORDS), .AW(MEM_AW), .W(STATE_W)) u_nvmem (
		.clk   (clk),
		.rst_n (rst_n),
		.mp    (mif.mem)
	);

	// ------------------------------------------------------------------
	// Command acceptance
	// ------------------------------------------------------------------
	// A query is refused while an earlier answer is still draining.
	always_comb begin
		acc      = cmd_valid && cmd_ready_ff;
		is_q     = cmd_code inside {CMD_ESE_Q, CMD_ESR_Q, CMD_IDN_Q,
			CMD_OPC_Q, CMD_OPT_Q, CMD_PSC_Q, CMD_SRE_Q, CMD_STB_Q};
		q_drop   = acc && is_q && resp_valid_ff;
		q_go     = acc && is_q && !resp_valid_ff;
		arg_ok   = cmd_arg < SLOT_COUNT;
		ops_idle = (pend_ff == '0) && !trig_busy;
		opc_set  = opc_armed_ff && ops_idle;
	end

	// Next control state.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_PU_RD: nxt_state = ST_PU_MASK;
			ST_PU_MASK: begin
				if (mif.rd_valid) begin
					nxt_state = power_up_state_select ? ST_RCL_WAIT : ST_IDLE;
				end
			end
			ST_RCL_WAIT: begin
				if (mif.rd_valid) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (acc) begin
					case (cmd_code)
						CMD_ESE, CMD_SRE, CMD_PSC: nxt_state = ST_NVWR;
						CMD_RCL: nxt_state = arg_ok ? ST_RCL_WAIT : ST_IDLE;
						CMD_OPC_Q: nxt_state = q_go ? ST_OPCQ : ST_IDLE;
						CMD_OTHER: nxt_state = cmd_overlap ? ST_IDLE : ST_SEQ;
						default: nxt_state = ST_IDLE;
					endcase
				end
			end
			ST_SEQ: begin
				if (exec_done) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_OPCQ: begin
				if (ops_idle) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_NVWR: nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	// State register and the ready flag that mirrors the idle state.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_ff     <= ST_PU_RD;
			cmd_ready_ff <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			cmd_ready_ff <= nxt_state == ST_IDLE;
		end
	end

	// ------------------------------------------------------------------
	// Storage port
	// ------------------------------------------------------------------
	// The mask word is written on a spare cycle so it never meets a save.
	always_comb begin
		mif.rd_en = (state_ff == ST_PU_RD) ||
			(state_ff == ST_PU_MASK && mif.rd_valid && power_up_state_select) ||
			(acc && cmd_code == CMD_RCL && arg_ok);
		mif.wr_en = (acc && cmd_code == CMD_SAV && arg_ok) ||
			(state_ff == ST_NVWR);
		if (state_ff == ST_PU_RD || state_ff == ST_NVWR) begin
			mif.addr = NV_WORD_IDX;
		end else if (state_ff == ST_PU_MASK) begin
			mif.addr = '0;
		end else begin
			mif.addr = cmd_arg[MEM_AW-1:0];
		end
		mif.wdata = (state_ff == ST_NVWR) ?
			STATE_W'({psc_ff, sre_ff, ese_ff}) : cur_state;
	end

	// ------------------------------------------------------------------
	// Masks and power-on clear flag
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ese_ff <= 8'h00;
			sre_ff <= 8'h00;
			psc_ff <= 1'b1;
		end else if (state_ff == ST_PU_MASK && mif.rd_valid) begin
			psc_ff <= mif.rdata[NV_PSC_BIT];
			// Only a word that says keep reloads; anything else clears.
			if (!mif.rdata[NV_PSC_BIT]) begin
				ese_ff <= mif.rdata[NV_ESE_LSB +: 8];
				sre_ff <= mif.rdata[NV_SRE_LSB +: 8];
			end else begin
				ese_ff <= 8'h00;
				sre_ff <= 8'h00;
			end
		end else if (acc) begin
			if (cmd_code == CMD_ESE) begin
				ese_ff <= cmd_arg;
			end
			if (cmd_code == CMD_SRE) begin
				sre_ff <= cmd_arg;
			end
			if (cmd_code == CMD_PSC) begin
				psc_ff <= cmd_arg[0];
			end
		end
	end

	// ------------------------------------------------------------------
	// Event flags
	// ------------------------------------------------------------------
	// New events win over a clear in the same cycle, so none is lost.
	always_comb begin
		ev = 8'h00;
		ev[EV_CMD_ERR]  = err_command;
		ev[EV_EXE_ERR]  = err_execution ||
			(acc && cmd_code inside {CMD_SAV, CMD_RCL} && !arg_ok);
		ev[EV_DEV_ERR]  = err_device;
		ev[EV_QRY_ERR]  = err_query || q_drop;
		ev[EV_OPS_DONE] = opc_set;
		esr_clr = acc && (cmd_code == CMD_CLS ||
			(cmd_code == CMD_ESR_Q && q_go));
		nxt_esr = ((esr_clr ? 8'h00 : esr_ff) | ev) & ESR_USED_MASK;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			esr_ff <= ESR_RESET;
		end else begin
			esr_ff <= nxt_esr;
		end
	end

	// Completion tracking: overlapped work and a pending completion request.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pend_ff      <= '0;
			opc_armed_ff <= 1'b0;
		end else begin
			if (acc && cmd_code == CMD_OTHER && cmd_overlap && !ovl_done) begin
				pend_ff <= pend_ff + PEND_W'(1);
			end else if (ovl_done && !(acc && cmd_code == CMD_OTHER &&
				cmd_overlap) && pend_ff != '0) begin
				pend_ff <= pend_ff - PEND_W'(1);
			end
			if (acc && cmd_code == CMD_OPC) begin
				opc_armed_ff <= 1'b1;
			end else if (opc_set) begin
				opc_armed_ff <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Status byte
	// ------------------------------------------------------------------
	always_comb begin
		event_summary_bit = |(esr_ff & ese_ff);
		stb_bits = {oper_summary, 1'b0, event_summary_bit, resp_valid_ff, ques_summary,
			3'b000};
		mss = |(stb_bits & sre_ff & STB_MSS_MASK);
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stb_ff <= 8'h00;
		end else begin
			stb_ff <= stb_bits | {1'b0, mss, 6'b000000};
		end
	end

	// ------------------------------------------------------------------
	// Output queue
	// ------------------------------------------------------------------
	function automatic logic [7:0] rsp_byte(input logic idn,
		input logic [7:0] val, input logic [IDXW-1:0] i);
		int sh;
		sh = 8 * (IDN_LEN - 1 - int'(i));
		return idn ? IDN_STR[sh +: 8] : val;
	endfunction

	// Which answer starts, and its first byte.
	always_comb begin
		start     = q_go && cmd_code != CMD_OPC_Q;
		start_idn = cmd_code == CMD_IDN_Q;
		case (cmd_code)
			CMD_ESE_Q: start_val = ese_ff;
			CMD_ESR_Q: start_val = esr_ff;
			CMD_SRE_Q: start_val = sre_ff;
			CMD_STB_Q: start_val = stb_ff;
			CMD_PSC_Q: start_val = {7'h00, psc_ff};
			CMD_OPT_Q: start_val = ASCII_ZERO;
			default:   start_val = 8'h00;
		endcase
		if (state_ff == ST_OPCQ && ops_idle) begin
			start     = 1'b1;
			start_idn = 1'b0;
			start_val = ASCII_ONE;
		end
	end

	// The message bit is this valid flag, so it falls with the last byte.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			resp_valid_ff <= 1'b0;
			resp_data_ff  <= 8'h00;
			rsp_val_ff    <= 8'h00;
			rsp_idn_ff    <= 1'b0;
			idx_ff        <= '0;
			rsp_len_ff    <= '0;
		end else if (acc && cmd_code == CMD_CLS && cmd_after_term) begin
			resp_valid_ff <= 1'b0;
		end else if (start) begin
			resp_valid_ff <= 1'b1;
			resp_data_ff  <= rsp_byte(start_idn, start_val, '0);
			rsp_val_ff    <= start_val;
			rsp_idn_ff    <= start_idn;
			idx_ff        <= IDXW'(1);
			rsp_len_ff    <= start_idn ? IDXW'(IDN_LEN) : IDXW'(1);
		end else if (resp_valid_ff && resp_ready) begin
			if (idx_ff == rsp_len_ff) begin
				resp_valid_ff <= 1'b0;
			end else begin
				resp_data_ff <= rsp_byte(rsp_idn_ff, rsp_val_ff, idx_ff);
				idx_ff       <= idx_ff + IDXW'(1);
			end
		end
	end

	// ------------------------------------------------------------------
	// Strobes to the neighbouring blocks
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			exec_start_ff   <= 1'b0;
			exec_overlap_ff <= 1'b0;
			clear_ff        <= 1'b0;
			flush_ff        <= 1'b0;
		end else begin
			exec_start_ff   <= acc && cmd_code == CMD_OTHER;
			exec_overlap_ff <= cmd_overlap;
			clear_ff        <= acc && cmd_code == CMD_CLS;
			flush_ff        <= acc && cmd_code == CMD_CLS && cmd_after_term;
		end
	end

	// Settings load: defaults on reset command, a slot on recall.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_load_ff  <= 1'b0;
			abort_ff       <= 1'b0;
			state_value_ff <= RST_STATE;
		end else if (acc && cmd_code == CMD_RST) begin
			state_load_ff  <= 1'b1;
			abort_ff       <= 1'b1;
			state_value_ff <= RST_STATE;
		end else if (state_ff == ST_RCL_WAIT && mif.rd_valid) begin
			state_load_ff  <= 1'b1;
			abort_ff       <= 1'b1;
			state_value_ff <= ccs_state_t'(mif.rdata);
			state_value_ff.cal_on <= 1'b0;
		end else begin
			state_load_ff <= 1'b0;
			abort_ff      <= 1'b0;
		end
	end

	assign cmd_ready    = cmd_ready_ff;
	assign exec_start   = exec_start_ff;
	assign exec_overlap = exec_overlap_ff;
	assign state_value  = state_value_ff;
	assign state_load   = state_load_ff;
	assign abort_trig   = abort_ff;
	assign clear_status = clear_ff;
	assign flush_outq   = flush_ff;
	assign resp_valid   = resp_valid_ff;
	assign resp_data    = resp_data_ff;
	assign status_byte  = stb_ff;
	assign event_flags  = esr_ff;
	assign event_mask   = ese_ff;
	assign service_mask = sre_ff;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_opcq_take;
		acc && cmd_code == CMD_OPC_Q && !resp_valid_ff;
	endsequence
	sequence s_opcq_release;
		state_ff == ST_OPCQ && ops_idle;
	endsequence
	sequence s_rcl_take;
		acc && cmd_code == CMD_RCL && arg_ok;
	endsequence

	property p_cls_clear;
		acc && cmd_code == CMD_CLS && ev == 8'h00 |=> esr_ff == 8'h00 &&
			clear_status;
	endproperty
	a_cls_clear: assert property (p_cls_clear) else $error("clear missed");
	property p_cls_flush;
		acc && cmd_code == CMD_CLS && cmd_after_term |=>
			!resp_valid && flush_outq ##1 !status_byte[SB_MAV];
	endproperty
	a_cls_flush: assert property (p_cls_flush) else $error("no flush");
	property p_esb;
		##1 status_byte[SB_ESB] == $past(|(esr_ff & ese_ff));
	endproperty
	a_esb: assert property (p_esb) else $error("summary wrong");
	property p_ese_rw;
		acc && cmd_code == CMD_ESE |=> ##1 event_mask == $past(cmd_arg, 2);
	endproperty
	a_ese_rw: assert property (p_ese_rw) else $error("mask not written");
	property p_rsvd;
		event_flags[6] == 1'b0 && event_flags[1] == 1'b0;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
	property p_esr_read;
		acc && cmd_code == CMD_ESR_Q && q_go && ev == 8'h00 |=>
			event_flags == 8'h00 && resp_data == $past(esr_ff);
	endproperty
	a_esr_read: assert property (p_esr_read) else $error("read no clear");
	property p_opc_set;
		$rose(event_flags[EV_OPS_DONE]) |-> $past(ops_idle && opc_armed_ff);
	endproperty
	a_opc_set: assert property (p_opc_set) else $error("early done");
	property p_seq_block;
		acc && cmd_code == CMD_OTHER && !cmd_overlap && !exec_done |=>
			exec_start && !exec_overlap && !cmd_ready;
	endproperty
	a_seq_block: assert property (p_seq_block) else $error("no block");
	property p_opcq_block;
		s_opcq_take |=> !cmd_ready;
	endproperty
	a_opcq_block: assert property (p_opcq_block) else $error("not held");
	property p_opcq_one;
		s_opcq_release |=> resp_valid && resp_data == ASCII_ONE && cmd_ready;
	endproperty
	a_opcq_one: assert property (p_opcq_one) else $error("no one");
	property p_idn_first;
		q_go && cmd_code == CMD_IDN_Q |=>
			resp_data == IDN_STR[8*IDN_LEN-1 -: 8];
	endproperty
	a_idn_first: assert property (p_idn_first) else $error("bad id");
	property p_opt;
		q_go && cmd_code == CMD_OPT_Q |=> resp_data == ASCII_ZERO;
	endproperty
	a_opt: assert property (p_opt) else $error("bad options");
	property p_psc_clear;
		state_ff == ST_PU_MASK && mif.rd_valid && mif.rdata[NV_PSC_BIT] |=>
			event_mask == 8'h00 && service_mask == 8'h00;
	endproperty
	a_psc_clear: assert property (p_psc_clear) else $error("mask kept");
	property p_rcl;
		s_rcl_take |=> ##1 state_load && abort_trig && !state_value.cal_on;
	endproperty
	a_rcl: assert property (p_rcl) else $error("recall failed");
	property p_rst;
		acc && cmd_code == CMD_RST |=> abort_trig && state_value == RST_STATE;
	endproperty
	a_rst: assert property (p_rst) else $error("reset defaults");
	property p_mss;
		##1 status_byte[SB_MSS] == $past(mss);
	endproperty
	a_mss: assert property (p_mss) else $error("service summary");
endmodule

// ===== common_command_status_unit_tb_top.sv
// Purpose: Self-checking bench for the common command and status unit.
// Assumes: Commands are driven on the falling clock edge.
// Notes:   Table rows first, then resets, completion, clearing and recall.
module common_command_status_unit_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import ccs_pkg::*;
	typedef struct {ccs_cmd_t c; logic [7:0] a; logic [3:0] e;
		logic r; logic [7:0] x;} ccs_row_t;
	logic clk = 0, rst_n = 0, cmd_valid = 0, term = 0, busy = 0;
	logic ovl = 1, pus = 0;
	logic [7:0] smask;
	logic cmd_ready, exec_start, exec_overlap, exec_done, ovl_done;
	logic state_load, abort_trig, resp_valid, resp_ready;
	ccs_cmd_t code = CMD_OTHER;
	logic [7:0] arg = 8'h00, resp_data, status_byte, event_flags, emask;
	logic [3:0] ev = 4'h0;
	ccs_state_t cs = RST_STATE, sv;
	int err_count = 0, compares = 0, cyc = 0, n;
	ccs_row_t rows[11] = '{
		'{CMD_PSC, 8'h00, 4'h0, 0, 8'h00}, '{CMD_ESE, 8'hFF, 4'h0, 0, 8'h00},
		'{CMD_SRE, 8'h24, 4'h0, 0, 8'h00},
		'{CMD_ESE_Q, 8'h00, 4'h0, 1, 8'hFF},
		'{CMD_ESR_Q, 8'h00, 4'h0, 1, 8'h80},
		'{CMD_ESR_Q, 8'h00, 4'h0, 1, 8'h00},
		'{CMD_ESR_Q, 8'h00, 4'hF, 1, 8'h3C},
		'{CMD_SAV, 8'h04, 4'h0, 0, 8'h00}, '{CMD_ESR_Q, 8'h00, 4'h0, 1, 8'h10},
		'{CMD_OPT_Q, 8'h00, 4'h0, 1, 8'h30},
		'{CMD_OPC_Q, 8'h00, 4'h0, 1, 8'h31}};
	always #50 clk = ~clk;
	ccs_status_unit i_dut (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
		.cmd_code(code), .cmd_arg(arg), .cmd_after_term(term),
		.cmd_overlap(ovl), .cmd_ready(cmd_ready), .exec_start(exec_start),
		.exec_overlap(exec_overlap), .exec_done(exec_done),
		.ovl_done(ovl_done), .trig_busy(busy), .err_command(ev[3]),
		.err_execution(ev[2]), .err_device(ev[1]), .err_query(ev[0]),
		.oper_summary(1'b0), .ques_summary(1'b0),
		.power_up_state_select(pus), .cur_state(cs), .state_value(sv),
		.state_load(state_load), .abort_trig(abort_trig),
		.clear_status(), .flush_outq(), .resp_valid(resp_valid),
		.resp_data(resp_data), .resp_ready(resp_ready),
		.status_byte(status_byte), .event_flags(event_flags),
		.event_mask(emask), .service_mask(smask));
	ccs_host_model i_host (.clk(clk), .rst_n(rst_n),
		.exec_start(exec_start), .exec_overlap(exec_overlap),
		.resp_valid(resp_valid), .exec_done(exec_done),
		.ovl_done(ovl_done), .resp_ready(resp_ready));
	// A hang ends the run as a failure.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			err_count++;
			results();
		end
	end
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Offer a command and hold it until the edge that takes it.
	task automatic send(input ccs_cmd_t c, input logic [7:0] a);
		@(negedge clk);
		cmd_valid = 1;
		code = c;
		arg = a;
		while (cmd_ready !== 1'b1) @(negedge clk);
		@(negedge clk);
		cmd_valid = 0;
	endtask
	task automatic take(output logic [7:0] b);
		while (!(resp_valid === 1'b1 && resp_ready === 1'b1)) @(negedge clk);
		b = resp_data;
		@(negedge clk);
	endtask
	task automatic pwr(input logic [7:0] exp);
		rst_n = 0;
		repeat (10) @(negedge clk);
		rst_n = 1;
		while (cmd_ready !== 1'b1) @(negedge clk);
		chk8(emask, exp);
		chk8(event_flags, 8'h80);
	endtask
	task automatic results();
		$display("compares=%0d err_count=%0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin : main
		logic [7:0] b;
		pwr(8'h00);
		foreach (rows[i]) begin
			ev = rows[i].e;
			@(negedge clk);
			ev = 4'h0;
			send(rows[i].c, rows[i].a);
			if (rows[i].r) take(b);
			if (rows[i].r) chk8(b, rows[i].x);
		end
		pwr(8'hFF);
		chk8(smask, 8'h24);
		send(CMD_IDN_Q, 8'h00);
		n = 0;
		repeat (21) begin
			take(b);
			n += (b === 8'h2C);
		end
		chk8(n[7:0], 8'h03);
		send(CMD_OTHER, 8'h00);
		busy = 1;
		send(CMD_OPC, 8'h00);
		repeat (8) @(negedge clk);
		chk8(event_flags, 8'h80);
		busy = 0;
		repeat (3) @(negedge clk);
		chk8(event_flags, 8'h81);
		ovl = 0;
		send(CMD_OTHER, 8'h00);
		chk8({7'h0, cmd_ready}, 8'h00);
		term = 1;
		send(CMD_CLS, 8'h00);
		@(negedge clk);
		chk8(event_flags, 8'h00);
		chk8(status_byte, 8'h00);
		cs.cal_on = 1;
		send(CMD_SAV, 8'h01);
		send(CMD_RCL, 8'h01);
		while (state_load !== 1'b1) @(negedge clk);
		chk8({7'h0, sv.cal_on}, 8'h00);
		send(CMD_RST, 8'h00);
		while (state_load !== 1'b1) @(negedge clk);
		chk8({7'h0, abort_trig}, 8'h01);
		chk8({7'h0, sv === RST_STATE}, 8'h01);
		send(CMD_PSC, 8'h01);
		send(CMD_SAV, 8'h00);
		pus = 1;
		pwr(8'h00);
		chk8(smask, 8'h00);
		chk8({6'h0, state_load, sv.cal_on}, 8'h02);
		results();
	end
endmodule
